// ===== design/dual_serial_register_port.sv
// dual_serial_register_port: two-wire and three-wire register access port.
// assumes a register store on core_clk that answers reg_rdata combinationally.
// Behaviour
// - sda change while scl high is condition
// - sda falling with scl high starts transfer
// - sda rising with scl high ends transfer
// - acknowledge a matching address and each written byte by pulling low
// - address 01110 plus two select pins
// - address lsb selects write or read
// - first write byte is pointer, range checked
// - pointer increments, saturating one past last
// - read data follows address byte immediately
// - read ends on stop or start
// - three-wire uses one shared data line
// - chip enable high resets three-wire frame logic
// - sample on rising, drive after falling
// - bytes travel most significant bit first
// - first byte holds direction and pointer
// - out of range start pointer ignored
// - pointer advances every eighth bit, saturating
// - read drives data until chip enable rises
`timescale 1ns/10ps
`default_nettype none

module dual_serial_register_port #(
  parameter logic [4:0] LAST_REG = port_pkg::PTR_LAST
) (
  // core clock, reset and enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // interface select and address straps
  input wire logic iface_spi,
  input wire logic addr_select_lo,
  input wire logic addr_select_hi,
  // two-wire pins
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  // three-wire pins, spi_clk is the link clock
  input wire logic spi_clk,
  input wire logic spi_ce_n,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  // register store side
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);

  initial begin
    if (LAST_REG > 5'h1d) begin
      $error("LAST_REG leaves no room for the saturation value");
    end
  end

  function automatic logic [4:0] next_ptr(input logic [4:0] p);
    next_ptr = (p > LAST_REG) ? p : 5'(p + 5'h01);
  endfunction : next_ptr

  // synchronisers and edge history
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic scl_q;
  logic sda_q;
  logic tog_q;

  // link side
  logic spi_tog;
  logic [7:0] spi_byte;
  logic spi_first;

  // pointer and transfer state
  logic [4:0] pointer;
  logic xfer_ok;
  logic spi_read;
  logic ptr_phase;
  logic [7:0] rd_byte;

  // two-wire engine
  port_pkg::i2c_state_e state;
  port_pkg::i2c_state_e next_state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic got8;
  logic rw;
  logic acked;
  logic next_oe;

  spi_link #(
    .LAST_REG(LAST_REG)
  ) u_link (
    .spi_clk(spi_clk),
    .spi_ce_n(spi_ce_n),
    .reset(reset),
    .sdio_in(spi_sdio_in),
    .sdio_out(spi_sdio_out),
    .sdio_oe(spi_sdio_oe),
    .ev_tog(spi_tog),
    .ev_byte(spi_byte),
    .ev_first(spi_first),
    .rd_byte(rd_byte)
  );

  // first stage feeds only the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_a <= port_pkg::SYNC_RESET;
      sync_b <= port_pkg::SYNC_RESET;
    end else if (clk_en) begin
      sync_a <= {spi_tog, iface_spi, addr_select_hi, addr_select_lo, i2c_scl, i2c_sda_in};
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      tog_q <= 1'b0;
    end else if (clk_en) begin
      scl_q <= sync_b[1];
      sda_q <= sync_b[0];
      tog_q <= sync_b[5];
    end
  end

  wire logic sda_s = sync_b[0];
  wire logic scl_s = sync_b[1];
  wire logic i2c_on = ~sync_b[4];
  wire logic spi_ev = (sync_b[5] ^ tog_q) & sync_b[4];
  wire logic scl_rise = scl_s & ~scl_q;
  wire logic scl_fall = ~scl_s & scl_q;
  wire logic start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire logic stop_c = scl_s & scl_q & ~sda_q & sda_s;
  wire logic addr_match = shift[7:3] == port_pkg::DEV_ADDR
                       && shift[2] == sync_b[3]
                       && shift[1] == sync_b[2];
  wire logic shifting = state == port_pkg::I_ADDR || state == port_pkg::I_RX
                     || state == port_pkg::I_TX;
  wire logic i2c_rx_done = scl_fall && state == port_pkg::I_RX && got8;
  wire logic i2c_ack_end = scl_fall && state == port_pkg::I_AACK;
  wire logic i2c_rd_start = i2c_ack_end && rw;
  wire logic i2c_tx_adv = scl_fall && state == port_pkg::I_TACK;
  wire logic ptr_take = i2c_rx_done && ptr_phase;
  wire logic i2c_ptr_ok = shift <= {3'h0, LAST_REG};
  wire logic spi_ptr_ok = spi_byte[4:0] <= LAST_REG;
  wire logic writable = pointer <= LAST_REG;

  always_comb begin
    next_state = state;
    if (!i2c_on) begin
      next_state = port_pkg::I_IDLE;
    end else if (start_c) begin
      next_state = port_pkg::I_ADDR;
    end else if (stop_c) begin
      next_state = port_pkg::I_IDLE;
    end else if (scl_fall) begin
      case (state)
        port_pkg::I_ADDR: begin
          if (got8) begin
            next_state = addr_match ? port_pkg::I_AACK : port_pkg::I_IDLE;
          end
        end
        port_pkg::I_AACK: begin
          next_state = rw ? port_pkg::I_TX : port_pkg::I_RX;
        end
        port_pkg::I_RX: begin
          if (got8) begin
            next_state = port_pkg::I_RACK;
          end
        end
        port_pkg::I_RACK: begin
          next_state = port_pkg::I_RX;
        end
        port_pkg::I_TX: begin
          if (got8) begin
            next_state = port_pkg::I_TACK;
          end
        end
        port_pkg::I_TACK: begin
          // a not-acknowledge just releases the line early
          next_state = acked ? port_pkg::I_TX : port_pkg::I_IDLE;
        end
        default: begin
          next_state = port_pkg::I_IDLE;
        end
      endcase
    end
  end

  // bit_cnt steps on scl rising, so scl_q pulls the index back until scl falls;
  // otherwise sda would move while scl is high and read as a start or stop
  wire logic [2:0] tx_idx = 3'(3'h7 - bit_cnt + {2'h0, scl_q});

  // open drain: enable high pulls the line low, the released line floats high
  assign next_oe = state == port_pkg::I_AACK || state == port_pkg::I_RACK
                || (state == port_pkg::I_TX && !rd_byte[tx_idx]);
  assign i2c_sda_out = 1'b0;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= port_pkg::I_IDLE;
      i2c_sda_oe <= 1'b0;
      acked <= 1'b0;
      rw <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      i2c_sda_oe <= next_oe;
      if (scl_rise && state == port_pkg::I_TACK) begin
        acked <= ~sda_s;
      end
      if (scl_fall && state == port_pkg::I_ADDR && got8) begin
        rw <= shift[port_pkg::ADDR_RW_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      got8 <= 1'b0;
    end else if (clk_en) begin
      if (start_c || next_state != state) begin
        bit_cnt <= 3'h0;
        got8 <= 1'b0;
      end else if (scl_rise && shifting) begin
        shift <= {shift[6:0], sda_s};
        bit_cnt <= 3'(bit_cnt + 3'h1);
        got8 <= bit_cnt == port_pkg::LAST_BIT;
      end
    end
  end

  // pointer, writes and read prefetch; events of the two engines never meet
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pointer <= port_pkg::PTR_RESET;
      xfer_ok <= 1'b0;
      spi_read <= 1'b0;
      ptr_phase <= 1'b0;
      reg_wr <= 1'b0;
      reg_wdata <= 8'h00;
      reg_rd <= 1'b0;
      rd_byte <= 8'h00;
    end else if (clk_en) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (reg_rd) begin
        rd_byte <= reg_rdata;
      end
      if (reg_wr) begin
        pointer <= next_ptr(pointer);
      end
      if (spi_ev && spi_first) begin
        xfer_ok <= spi_ptr_ok;
        spi_read <= spi_byte[port_pkg::SPI_RW_BIT];
        if (spi_ptr_ok) begin
          pointer <= spi_byte[4:0];
          reg_rd <= spi_byte[port_pkg::SPI_RW_BIT];
        end
      end else if (spi_ev && xfer_ok && spi_read) begin
        pointer <= next_ptr(pointer);
        reg_rd <= 1'b1;
      end else if (spi_ev && xfer_ok) begin
        reg_wr <= writable;
        reg_wdata <= spi_byte;
      end
      if (i2c_ack_end && !rw) begin
        ptr_phase <= 1'b1;
      end
      if (ptr_take) begin
        ptr_phase <= 1'b0;
        xfer_ok <= i2c_ptr_ok;
        if (i2c_ptr_ok) begin
          pointer <= shift[4:0];
        end
      end else if (i2c_rx_done && xfer_ok) begin
        reg_wr <= writable;
        reg_wdata <= shift;
      end
      if (i2c_rd_start) begin
        reg_rd <= 1'b1;
      end
      if (i2c_tx_adv) begin
        pointer <= next_ptr(pointer);
        reg_rd <= 1'b1;
      end
    end
  end

  assign reg_addr = pointer;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset || !clk_en);

  property p_start_addr;
    (i2c_on && start_c) |=> (state == port_pkg::I_ADDR);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_stop_idle;
    (i2c_on && stop_c) |=> (state == port_pkg::I_IDLE);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

  property p_ack_drive;
    (state == port_pkg::I_RACK) ##1 (state == port_pkg::I_RACK) |-> i2c_sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("no acknowledge");

  property p_addr_match;
    (i2c_on && !start_c && !stop_c && scl_fall && state == port_pkg::I_ADDR && got8)
      |=> (state == ($past(addr_match) ? port_pkg::I_AACK : port_pkg::I_IDLE));
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("address decode");

  property p_dir;
    (i2c_on && !start_c && !stop_c && i2c_ack_end)
      |=> (state == (rw ? port_pkg::I_TX : port_pkg::I_RX));
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");

  property p_range;
    (ptr_take && !i2c_ptr_ok) |=> !xfer_ok ##1 !reg_wr;
  endproperty
  a_range: assert property (p_range) else $error("bad pointer accepted");

  property p_sat;
    reg_wr |-> writable ##1 (pointer == next_ptr($past(pointer)));
  endproperty
  a_sat: assert property (p_sat) else $error("pointer step");

  property p_fetch;
    i2c_rd_start |=> reg_rd ##1 (rd_byte == $past(reg_rdata));
  endproperty
  a_fetch: assert property (p_fetch) else $error("read fetch");

  property p_spi_range;
    (spi_ev && spi_first && !spi_ptr_ok) |=> !xfer_ok;
  endproperty
  a_spi_range: assert property (p_spi_range) else $error("spi pointer");

  property p_hold;
    !$stable(pointer) |-> $past(spi_ev || i2c_rx_done || i2c_tx_adv || reg_wr);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved");

  c_i2c_write: cover property (i2c_rx_done && xfer_ok ##1 reg_wr);
  c_i2c_read: cover property (i2c_tx_adv && acked);
  c_spi_read: cover property (spi_ev && xfer_ok && spi_read);
  c_saturate: cover property (reg_wr && pointer == LAST_REG);

endmodule : dual_serial_register_port

`default_nettype wire

// ===== pkg/port_pkg.sv
// port_pkg: constants and state encoding shared by the serial register port.
// assumes a single core clock domain plus one link clock owned by the host.
package port_pkg;

  // register pointer range and reset value
  localparam logic [4:0] PTR_LAST = 5'h17;
  localparam logic [4:0] PTR_RESET = 5'h00;

  // fixed upper five bits of the two-wire device address (01110)
  localparam logic [4:0] DEV_ADDR = 5'h0e;

  // field positions
  localparam int ADDR_RW_BIT = 0;
  localparam int SPI_RW_BIT = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // reset value of the pin synchronisers; scl and sda idle high
  localparam logic [5:0] SYNC_RESET = 6'h03;

  // two-wire engine states, gray coded along address -> data path
  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_ADDR = 3'h1,
    I_AACK = 3'h3,
    I_RX = 3'h2,
    I_RACK = 3'h6,
    I_TX = 3'h7,
    I_TACK = 3'h5
  } i2c_state_e;

endpackage : port_pkg

// ===== design/spi_link.sv
// spi_link: three-wire slave logic running on the host's serial clock.
// assumes mode with clock idle low; chip enable high resets the frame logic.
`timescale 1ns/10ps
`default_nettype none

module spi_link #(
  parameter logic [4:0] LAST_REG = port_pkg::PTR_LAST
) (
  // link clock, frame and reset
  input wire logic spi_clk,
  input wire logic spi_ce_n,
  input wire logic reset,
  // shared data line
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // byte events toward the core domain
  output logic ev_tog,
  output logic [7:0] ev_byte,
  output logic ev_first,
  // read byte, held stable by the core domain between events
  input wire logic [7:0] rd_byte
);

  logic frame_rst;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic first;
  logic rd_mode;
  logic skip;
  logic [7:0] out_sh;
  logic msb_phase;
  wire logic [7:0] next_byte;
  wire logic byte_end;

  assign next_byte = {shift_in[6:0], sdio_in};
  assign byte_end = bit_cnt == port_pkg::LAST_BIT;
  assign frame_rst = spi_ce_n | reset;

  always_ff @(posedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
      first <= 1'b1;
      rd_mode <= 1'b0;
      skip <= 1'b0;
    end else begin
      shift_in <= next_byte;
      bit_cnt <= 3'(bit_cnt + 3'h1);
      if (byte_end) begin
        first <= 1'b0;
      end
      if (byte_end && first) begin
        rd_mode <= next_byte[port_pkg::SPI_RW_BIT];
        skip <= next_byte[4:0] > LAST_REG;
      end
    end
  end

  // the toggle must survive chip enable, so only the core reset clears it
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      ev_tog <= 1'b0;
      ev_byte <= 8'h00;
      ev_first <= 1'b0;
    end else if (byte_end) begin
      ev_tog <= ~ev_tog;
      ev_byte <= next_byte;
      ev_first <= first;
    end
  end

  always_ff @(negedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      out_sh <= 8'h00;
      msb_phase <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      msb_phase <= bit_cnt == 3'h0;
      out_sh <= (bit_cnt == 3'h1) ? {rd_byte[6:0], 1'b0} : {out_sh[6:0], 1'b0};
      sdio_oe <= rd_mode && !first && !skip;
    end
  end

  // msb passes straight from the core-held byte: it settles within half a
  // link period of the event, well before the host samples it
  assign sdio_out = msb_phase ? rd_byte[7] : out_sh[7];

endmodule : spi_link

`default_nettype wire

// ===== test/serial_host.sv
// serial_host: host master model driving both serial ports of the register port.
// assumes core_clk paces the two-wire side; the link clock runs only inside frames.
`timescale 1ns/10ps
`default_nettype none
module serial_host (
  // core clock for two-wire pacing
  input wire logic core_clk,
  // two-wire side
  output logic scl,
  output logic sda_in,
  input wire logic sda_oe,
  // three-wire side
  output logic spi_clk,
  output logic ce_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  localparam int Q = 10;
  logic sda_drv = 1'b1;
  logic sdio_drv = 1'b0;
  logic oe_seen = 1'b0;
  // open drain with pull-up: any low wins
  assign sda_in = sda_oe ? 1'b0 : sda_drv;
  // one shared data line; the device drive wins while enabled
  assign sdio_in = sdio_oe ? sdio_out : sdio_drv;
  initial begin
    scl = 1'b1;
    spi_clk = 1'b0;
    ce_n = 1'b1;
  end
  always @(posedge core_clk) begin
    if (sdio_oe) oe_seen <= 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // data changes only while scl is low
  task automatic bit9(input logic b, output logic r);
    sda_drv <= b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    r = sda_in;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : bit9
  task automatic i2c_byte(input logic [7:0] d, input logic b9, output logic [7:0] r,
                          output logic a);
    for (int i = 7; i >= 0; i--) bit9(d[i], r[i]);
    bit9(b9, a);
  endtask : i2c_byte
  // from idle or after an ack clock; doubles as repeated start
  task automatic i2c_start();
    sda_drv <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b0;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : i2c_start
  task automatic i2c_stop();
    sda_drv <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b1;
    tick(Q);
  endtask : i2c_stop
  task automatic spi_begin();
    oe_seen = 1'b0;
    ce_n <= 1'b0;
    #40;
  endtask : spi_begin
  // bits from msb down; host samples on rising as well
  task automatic spi_byte(input logic [7:0] d, input int nb, output logic [7:0] r);
    for (int i = 7; i >= 8 - nb; i--) begin
      sdio_drv <= d[i];
      #40 spi_clk <= 1'b1;
      r[i] = sdio_in;
      #40 spi_clk <= 1'b0;
    end
  endtask : spi_byte
  task automatic spi_end();
    #40 ce_n <= 1'b1;
    #120;
  endtask : spi_end
endmodule : serial_host
`default_nettype wire

// ===== test/tb_top.sv
// tb_top: random and corner traffic over both serial ports, checked against a model.
// assumes the register store answers reg_rdata combinationally from reg_addr.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [4:0] LAST = port_pkg::PTR_LAST;
  localparam logic [4:0] DEV = port_pkg::DEV_ADDR;
  // slot holding display_on_bit; the slot number is arbitrary
  localparam logic [4:0] DISP_REG = 5'h01;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic iface_spi = 1'b0;
  logic addr_select_lo = 1'b0;
  logic addr_select_hi = 1'b0;
  wire logic i2c_scl, i2c_sda_in, i2c_sda_oe, spi_clk, spi_ce_n, spi_sdio_in;
  wire logic spi_sdio_out, spi_sdio_oe, reg_wr, reg_rd;
  wire logic [4:0] reg_addr;
  wire logic [7:0] reg_wdata;
  wire logic [7:0] reg_rdata;
  logic [7:0] mem [0:31];
  logic [7:0] want_mem [0:31];
  logic [4:0] ptr;
  logic [31:0] seed = 32'hed6f;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  dual_serial_register_port dual_serial_register_port_i (.core_clk(core_clk), .reset(reset),
    .clk_en(1'b1), .iface_spi(iface_spi), .addr_select_lo(addr_select_lo),
    .addr_select_hi(addr_select_hi), .i2c_scl(i2c_scl), .i2c_sda_in(i2c_sda_in),
    .i2c_sda_out(), .i2c_sda_oe(i2c_sda_oe), .spi_clk(spi_clk), .spi_ce_n(spi_ce_n),
    .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  serial_host serial_host_i (.core_clk(core_clk), .scl(i2c_scl), .sda_in(i2c_sda_in),
    .sda_oe(i2c_sda_oe), .spi_clk(spi_clk), .ce_n(spi_ce_n), .sdio_in(spi_sdio_in),
    .sdio_out(spi_sdio_out), .sdio_oe(spi_sdio_oe));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // register store; slots 24 and 25, above the last register, hold marks to expose overrun
  assign reg_rdata = mem[reg_addr];
  always @(posedge core_clk) begin
    if (reg_wr) mem[reg_addr] <= reg_wdata;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [4:0] nxt(input logic [4:0] p);
    return (p <= LAST) ? p + 5'h01 : p;
  endfunction : nxt
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic i2c_wr(input logic [7:0] adr, input logic [7:0] p, input int n,
                        input logic nak, input logic sr);
    logic [7:0] r;
    logic [7:0] d;
    logic a;
    logic ok;
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte(adr, 1'b1, r, a);
    check("addr ack", {7'h00, a}, {7'h00, nak});
    if (!nak) begin
      serial_host_i.i2c_byte(p, 1'b1, r, a);
      check("ptr ack", {7'h00, a}, 8'h00);
      ok = p <= {3'h0, LAST};
      ptr = p[4:0];
      for (int k = 0; k < n; k++) begin
        d = 8'(rnd() >> 8);
        serial_host_i.i2c_byte(d, 1'b1, r, a);
        check("data ack", {7'h00, a}, 8'h00);
        if (ok && ptr <= LAST) want_mem[ptr] = d;
        ptr = nxt(ptr);
      end
    end
    if (!sr) serial_host_i.i2c_stop();
  endtask : i2c_wr
  task automatic i2c_rd(input int n);
    logic [7:0] r;
    logic a;
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte({DEV, addr_select_hi, addr_select_lo, 1'b1}, 1'b1, r, a);
    check("rd addr ack", {7'h00, a}, 8'h00);
    for (int k = 0; k < n; k++) begin
      serial_host_i.i2c_byte(8'hff, k == n - 1, r, a);
      check("i2c rd", r, want_mem[ptr]);
      ptr = nxt(ptr);
    end
    serial_host_i.i2c_stop();
  endtask : i2c_rd
  task automatic spi_xfer(input logic [7:0] cmd, input int n);
    logic [7:0] r;
    logic [7:0] d;
    logic ok;
    serial_host_i.spi_begin();
    serial_host_i.spi_byte(cmd, 8, r);
    ok = cmd[4:0] <= LAST;
    ptr = cmd[4:0];
    for (int k = 0; k < n; k++) begin
      d = cmd[7] ? 8'haa : 8'(rnd() >> 8);
      serial_host_i.spi_byte(d, 8, r);
      if (ok && cmd[7]) check("spi rd", r, want_mem[ptr]);
      if (ok && !cmd[7] && ptr <= LAST) want_mem[ptr] = d;
      ptr = nxt(ptr);
    end
    serial_host_i.spi_end();
    check("spi drive", {7'h00, serial_host_i.oe_seen}, {7'h00, cmd[7] & ok});
  endtask : spi_xfer
  task automatic cmp_all();
    for (int i = 0; i < 32; i++) check("reg", mem[i], want_mem[i]);
  endtask : cmp_all
  initial begin
    logic [7:0] r;
    logic [7:0] good;
    logic [4:0] p;
    for (int i = 0; i < 32; i++) mem[i] = 8'h00;
    mem[24] = 8'h5a;
    mem[25] = 8'ha5;
    for (int i = 0; i < 32; i++) want_mem[i] = mem[i];
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
    for (int s = 0; s < 4; s++) begin
      {addr_select_hi, addr_select_lo} <= s[1:0];
      repeat (8) @(posedge core_clk);
      i2c_wr({DEV, ~s[1:0], 1'b0}, 8'h00, 0, 1'b1, 1'b0);
      i2c_wr({DEV, s[1:0], 1'b0}, 8'(rnd() % 32'd24), 2, 1'b0, 1'b0);
    end
    good = {DEV, addr_select_hi, addr_select_lo, 1'b0};
    i2c_wr(good, 8'h18, 2, 1'b0, 1'b0);
    i2c_wr(good, 8'hc3, 1, 1'b0, 1'b0);
    i2c_wr(good, 8'h16, 3, 1'b0, 1'b0);
    // pointer preset then repeated start straight into the read
    i2c_wr(good, 8'(rnd() % 32'd20), 0, 1'b0, 1'b1);
    i2c_rd(3);
    i2c_rd(2);
    i2c_wr(good, 8'h15, 0, 1'b0, 1'b0);
    i2c_rd(5);
    cmp_all();
    iface_spi <= 1'b1;
    repeat (8) @(posedge core_clk);
    #3.3;
    p = 5'(rnd() % 32'd20);
    spi_xfer({3'h0, p}, 3);
    spi_xfer({3'h4, p}, 4);
    spi_xfer(8'h1a, 2);
    spi_xfer(8'h9b, 2);
    spi_xfer(8'h16, 3);
    spi_xfer(8'h95, 5);
    // frame cut short mid byte must not shift the next command
    serial_host_i.spi_begin();
    serial_host_i.spi_byte(8'hff, 4, r);
    serial_host_i.spi_end();
    spi_xfer(8'h05, 1);
    spi_xfer(8'h85, 1);
    // display off before power is removed: clear the whole display control slot
    serial_host_i.spi_begin();
    serial_host_i.spi_byte({3'h0, DISP_REG}, 8, r);
    serial_host_i.spi_byte(8'h00, 8, r);
    serial_host_i.spi_end();
    want_mem[DISP_REG] = 8'h00;
    cmp_all();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
